// ### hdl/sdsc_top.sv
// sent slow channel messages, status nibble and fast channel diagnostics
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sdsc_top
   import sdsc_pkg::*;
(
   input wire logic clk_i, // 20 mhz clock
   input wire logic rst_i, // sync reset, active high
   input wire logic [7:0] addr_i, // register address
   input wire logic [15:0] wdata_i, // register write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [15:0] rdata_o, // read data, one cycle after rd_i
   input wire logic msg_next_i, // advance slow channel message
   input wire logic diag_mode_i, // device in diagnostic mode
   input wire logic [11:0] asil_flags_i, // safety mechanism flags
   input wire logic sbe_i, // corrected memory bit error
   input wire logic [11:0] angle_i, // measured angle
   input wire logic [8:0] supply_i, // supply measurement
   input wire logic [7:0] temp_i, // temperature measurement
   output logic [7:0] msg_id_o, // slow channel identifier
   output logic [11:0] msg_data_o, // slow channel payload
   output logic [3:0] status_o, // status nibble
   output logic [11:0] fast_o // fast channel value
);
   // register map (word offsets)
   localparam logic [7:0] A_CW1 = 8'h00;
   localparam logic [7:0] A_CW2 = 8'h01;
   localparam logic [7:0] A_SEL = 8'h02;
   localparam logic [7:0] A_OOR_HI = 8'h03;
   localparam logic [7:0] A_OOR_LO = 8'h04;
   localparam logic [7:0] A_VLIM = 8'h05;
   localparam logic [7:0] A_TLIM = 8'h06;
   localparam logic [7:0] A_ZERO = 8'h07;
   localparam logic [7:0] A_RANGE = 8'h08;
   localparam logic [7:0] A_CSW = 8'h09;
   localparam logic [7:0] A_CLO = 8'h0a;
   localparam logic [7:0] A_CHI = 8'h0b;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_USER0 = 8'h10;
   localparam logic [7:0] A_COEF0 = 8'h20;
   parameter logic [11:0] MAKER_CODE = 12'h5a5; // arbitrary value
   parameter logic [11:0] TYPE_CODE = 12'h059; // sensor type, plain default

   logic [15:0] cw1_r, cw1_nxt, cw2_r, cw2_nxt, sel_r, sel_nxt;
   logic [11:0] oor_hi_r, oor_hi_nxt, oor_lo_r, oor_lo_nxt;
   logic [8:0] vlo_r, vlo_nxt, vhi_r, vhi_nxt;
   logic [7:0] tlim_r, tlim_nxt;
   logic [11:0] zero_r, zero_nxt, range_r, range_nxt, csw_r, csw_nxt;
   logic [11:0] clo_r, clo_nxt, chi_r, chi_nxt;
   logic [11:0] user_r [8];
   logic [11:0] user_nxt [8];
   logic [15:0] rdata_r, rdata_nxt;
   logic coef_we;

   // synchronised measurement inputs
   logic diag_s1_r, diag_s2_r, sbe_s1_r, sbe_s2_r;
   logic [11:0] ang_s1_r, ang_s2_r;
   logic [8:0] sup_s1_r, sup_s2_r;
   logic [7:0] tmp_s1_r, tmp_s2_r;

   // slow channel
   logic [4:0] slot_r, slot_nxt;
   logic [7:0] id_r, id_nxt;
   logic [11:0] pay_r, pay_nxt;
   logic [3:0] stat_r, stat_nxt;
   logic [11:0] fast_r, fast_nxt;
   logic [11:0] diag_code;
   logic w_oor_hi, w_oor_lo, w_under, w_over, w_temp, warn;
   logic [11:0] curve_out;

   sdsc_coef_if cif ();

   //////////////////////////////////////////////////////////////////////////
   // registers reached over the plain port
   always_comb begin
      cw1_nxt = cw1_r;
      cw2_nxt = cw2_r;
      sel_nxt = sel_r;
      oor_hi_nxt = oor_hi_r;
      oor_lo_nxt = oor_lo_r;
      vlo_nxt = vlo_r;
      vhi_nxt = vhi_r;
      tlim_nxt = tlim_r;
      zero_nxt = zero_r;
      range_nxt = range_r;
      csw_nxt = csw_r;
      clo_nxt = clo_r;
      chi_nxt = chi_r;
      user_nxt = user_r;
      coef_we = 1'b0;
      if (wr_i) begin
         if (addr_i == A_CW1) begin
            cw1_nxt = wdata_i;
         end else if (addr_i == A_CW2) begin
            cw2_nxt = wdata_i;
         end else if (addr_i == A_SEL) begin
            sel_nxt = wdata_i;
         end else if (addr_i == A_OOR_HI) begin
            oor_hi_nxt = wdata_i[11:0];
         end else if (addr_i == A_OOR_LO) begin
            oor_lo_nxt = wdata_i[11:0];
         end else if (addr_i == A_VLIM) begin
            vlo_nxt = {1'b0, wdata_i[7:0]};
            vhi_nxt = {1'b1, wdata_i[15:8]};
         end else if (addr_i == A_TLIM) begin
            tlim_nxt = wdata_i[7:0];
         end else if (addr_i == A_ZERO) begin
            zero_nxt = wdata_i[11:0];
         end else if (addr_i == A_RANGE) begin
            range_nxt = wdata_i[11:0];
         end else if (addr_i == A_CSW) begin
            csw_nxt = wdata_i[11:0];
         end else if (addr_i == A_CLO) begin
            clo_nxt = wdata_i[11:0];
         end else if (addr_i == A_CHI) begin
            chi_nxt = wdata_i[11:0];
         end else if (addr_i[7:3] == A_USER0[7:3]) begin
            user_nxt[addr_i[2:0]] = wdata_i[11:0];
         end else if (addr_i[7:4] == A_COEF0[7:4]) begin
            coef_we = 1'b1;
         end
      end
      // read answer; unmapped addresses read zero
      rdata_nxt = 16'h0000;
      if (rd_i) begin
         if (addr_i == A_CW1) begin
            rdata_nxt = cw1_r;
         end else if (addr_i == A_CW2) begin
            rdata_nxt = cw2_r;
         end else if (addr_i == A_SEL) begin
            rdata_nxt = sel_r;
         end else if (addr_i == A_STAT) begin
            rdata_nxt = {stat_r, 7'h00, slot_r};
         end else if (addr_i[7:3] == A_USER0[7:3]) begin
            rdata_nxt = {4'h0, user_r[addr_i[2:0]]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cw1_r <= 16'h0001;
         cw2_r <= 16'h0000;
         sel_r <= 16'h0000;
         oor_hi_r <= SDSC_ONES12;
         oor_lo_r <= SDSC_ZERO12;
         vlo_r <= 9'h000;
         vhi_r <= 9'h1ff;
         tlim_r <= 8'hff;
         zero_r <= SDSC_ZERO12;
         range_r <= SDSC_ONES12;
         csw_r <= SDSC_ONES12;
         clo_r <= SDSC_ZERO12;
         chi_r <= SDSC_ONES12;
         user_r <= '{default: SDSC_ZERO12};
         rdata_r <= 16'h0000;
      end else begin
         cw1_r <= cw1_nxt;
         cw2_r <= cw2_nxt;
         sel_r <= sel_nxt;
         oor_hi_r <= oor_hi_nxt;
         oor_lo_r <= oor_lo_nxt;
         vlo_r <= vlo_nxt;
         vhi_r <= vhi_nxt;
         tlim_r <= tlim_nxt;
         zero_r <= zero_nxt;
         range_r <= range_nxt;
         csw_r <= csw_nxt;
         clo_r <= clo_nxt;
         chi_r <= chi_nxt;
         user_r <= user_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for measurement and status inputs
   always_ff @(posedge clk_i) begin
      diag_s1_r <= diag_mode_i;
      diag_s2_r <= diag_s1_r;
      sbe_s1_r <= sbe_i;
      sbe_s2_r <= sbe_s1_r;
      ang_s1_r <= angle_i;
      ang_s2_r <= ang_s1_r;
      sup_s1_r <= supply_i;
      sup_s2_r <= sup_s1_r;
      tmp_s1_r <= temp_i;
      tmp_s2_r <= tmp_s1_r;
   end

   //////////////////////////////////////////////////////////////////////////
   // curve and its coefficient store
   sdsc_coef_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(coef_we),
      .waddr_i(addr_i[3:0]),
      .wdata_i(wdata_i[11:0]),
      .port_b(cif.mem)
   );

   sdsc_curve u_curve (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cal_mode_i(sel_r[9:8]),
      .neg_slope_i(sel_r[10]),
      .angle_i(ang_s2_r),
      .zero_angle_i(zero_r),
      .range_i(range_r),
      .clamp_switch_i(csw_r),
      .clamp_lo_i(clo_r),
      .clamp_hi_i(chi_r),
      .coef(cif.user),
      .out_o(curve_out)
   );

   //////////////////////////////////////////////////////////////////////////
   // warnings, diagnostic code and slow channel payload
   always_comb begin
      w_oor_hi = curve_out > oor_hi_r;
      w_oor_lo = curve_out < oor_lo_r;
      w_under = sup_s2_r < vlo_r;
      w_over = sup_s2_r > vhi_r;
      w_temp = tmp_s2_r > tlim_r;
      warn = w_oor_hi | w_oor_lo | w_under | w_over | w_temp | sbe_s2_r;
      // most severe first: diagnostic mode, then warnings
      if (diag_s2_r) begin
         diag_code = SDSC_DC_ASIL | asil_flags_i;
      end else if (w_oor_hi) begin
         diag_code = SDSC_DC_OOR_HI;
      end else if (w_oor_lo) begin
         diag_code = SDSC_DC_OOR_LO;
      end else if (w_under) begin
         diag_code = SDSC_DC_UNDER;
      end else if (w_over) begin
         diag_code = SDSC_DC_OVER;
      end else if (w_temp) begin
         diag_code = SDSC_DC_TEMP;
      end else if (sbe_s2_r) begin
         diag_code = SDSC_DC_SBE;
      end else begin
         diag_code = SDSC_ZERO12;
      end
      if (!cw1_r[SDSC_CW1_ESP]) begin
         diag_code = SDSC_ZERO12;
      end

      slot_nxt = slot_r;
      if (msg_next_i) begin
         slot_nxt = (slot_r == SDSC_LAST_SLOT) ? 5'h00 : slot_r + 5'h01;
      end
      // fixed schedule: diag/temp/supply twice
      id_nxt = SDSC_ID_DIAG;
      pay_nxt = diag_code;
      case (slot_nxt)
         5'h01, 5'h08: begin
            id_nxt = SDSC_ID_TEMP;
            pay_nxt = {4'h0, tmp_s2_r};
         end
         5'h02, 5'h09: begin
            id_nxt = SDSC_ID_SUPPLY;
            pay_nxt = {3'h0, sup_s2_r};
         end
         5'h03: begin
            id_nxt = SDSC_ID_TYPE;
            pay_nxt = TYPE_CODE;
         end
         5'h04: begin
            id_nxt = SDSC_ID_UNIT;
            pay_nxt = sel_r[2] ? SDSC_ONES12 : SDSC_ZERO12;
         end
         5'h05: begin
            id_nxt = SDSC_ID_MAKER;
            pay_nxt = MAKER_CODE;
         end
         5'h06: begin
            id_nxt = SDSC_ID_REV;
            case (sel_r[1:0])
               2'h0: pay_nxt = SDSC_REV_P0;
               2'h1: pay_nxt = SDSC_REV_P1;
               2'h2: pay_nxt = SDSC_REV_P2;
               default: pay_nxt = SDSC_REV_P3;
            endcase
         end
         5'h00, 5'h07: begin
            id_nxt = SDSC_ID_DIAG;
         end
         default: begin
            id_nxt = SDSC_ID_USER0 + 8'(slot_nxt - 5'h0a);
            pay_nxt = user_r[3'(slot_nxt - 5'h0a)];
         end
      endcase

      // status nibble; checksum elsewhere omits it
      stat_nxt = 4'h0;
      stat_nxt[SDSC_ST_DIAG] = diag_s2_r & ~cw2_r[SDSC_CW2_MASK_DIAG];
      stat_nxt[SDSC_ST_WARN] = warn & ~diag_s2_r & ~cw2_r[SDSC_CW2_MASK_WARN];

      // fast channel substitution by format
      fast_nxt = curve_out;
      if (diag_s2_r) begin
         case (sel_r[6:4])
            3'(SDSC_FMT_A1): fast_nxt = SDSC_FC_DIAG_A;
            3'(SDSC_FMT_A3): fast_nxt = curve_out;
            default: fast_nxt = SDSC_FC_DIAG_H;
         endcase
      end
   end

   // message slot, payload and nibble registers; 8+12 bit frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_r <= 5'h00;
         id_r <= SDSC_ID_DIAG;
         pay_r <= SDSC_ZERO12;
         stat_r <= 4'h0;
         fast_r <= SDSC_ZERO12;
      end else begin
         slot_r <= slot_nxt;
         id_r <= id_nxt;
         pay_r <= pay_nxt;
         stat_r <= stat_nxt;
         fast_r <= fast_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign msg_id_o = id_r;
   assign msg_data_o = pay_r;
   assign status_o = stat_r;
   assign fast_o = fast_r;

   //////////////////////////////////////////////////////////////////////////
   // checks
   property p_diag_mask;
      @(posedge clk_i) disable iff (rst_i) cw2_r[SDSC_CW2_MASK_DIAG] |=> !status_o[SDSC_ST_DIAG];
   endproperty
   a_diag_mask: assert property (p_diag_mask) else $error("diag bit not masked");
   property p_warn_mask;
      @(posedge clk_i) disable iff (rst_i) cw2_r[SDSC_CW2_MASK_WARN] |=> !status_o[SDSC_ST_WARN];
   endproperty
   a_warn_mask: assert property (p_warn_mask) else $error("warn bit not masked");
   property p_diag_bit;
      @(posedge clk_i) disable iff (rst_i)
         diag_s2_r && !cw2_r[SDSC_CW2_MASK_DIAG] |=> status_o[SDSC_ST_DIAG];
   endproperty
   a_diag_bit: assert property (p_diag_bit) else $error("diag bit missing");
   property p_fast_a1;
      @(posedge clk_i) disable iff (rst_i)
         diag_s2_r && sel_r[6:4] == 3'(SDSC_FMT_A1) |=> fast_o == SDSC_FC_DIAG_A;
   endproperty
   a_fast_a1: assert property (p_fast_a1) else $error("format a1 substitute wrong");
   property p_rev;
      @(posedge clk_i) disable iff (rst_i)
         msg_id_o == SDSC_ID_REV |-> msg_data_o == (($past(sel_r[1:0]) == 2'h0) ? SDSC_REV_P0
            : ($past(sel_r[1:0]) == 2'h1) ? SDSC_REV_P1
            : ($past(sel_r[1:0]) == 2'h2) ? SDSC_REV_P2 : SDSC_REV_P3);
   endproperty
   a_rev: assert property (p_rev) else $error("revision payload wrong");
   property p_maker;
      @(posedge clk_i) disable iff (rst_i) msg_id_o == SDSC_ID_MAKER |-> msg_data_o == MAKER_CODE;
   endproperty
   a_maker: assert property (p_maker) else $error("maker code wrong");
   property p_esp;
      @(posedge clk_i) disable iff (rst_i)
         !cw1_r[SDSC_CW1_ESP] && $stable(cw1_r) && msg_id_o == SDSC_ID_DIAG
            |-> msg_data_o == SDSC_ZERO12;
   endproperty
   a_esp: assert property (p_esp) else $error("detail code without enable");
   property p_wrap;
      @(posedge clk_i) disable iff (rst_i)
         msg_next_i && slot_r == SDSC_LAST_SLOT |=> slot_r == 5'h00 && msg_id_o == SDSC_ID_DIAG;
   endproperty
   a_wrap: assert property (p_wrap) else $error("cycle wrap wrong");
endmodule : sdsc_top
`default_nettype wire

// ### common/sdsc_pkg.sv
// shared constants and types for the sent diagnostic and slow channel block
package sdsc_pkg;
   // slow channel message identifiers
   localparam logic [7:0] SDSC_ID_DIAG = 8'h01;
   localparam logic [7:0] SDSC_ID_TYPE = 8'h03;
   localparam logic [7:0] SDSC_ID_MAKER = 8'h05;
   localparam logic [7:0] SDSC_ID_REV = 8'h06;
   localparam logic [7:0] SDSC_ID_SUPPLY = 8'h1c;
   localparam logic [7:0] SDSC_ID_TEMP = 8'h23;
   localparam logic [7:0] SDSC_ID_UNIT = 8'h29;
   localparam logic [7:0] SDSC_ID_USER0 = 8'h90;
   // message cycle
   localparam int SDSC_NUM_MSG = 18;
   localparam logic [4:0] SDSC_LAST_SLOT = 5'h11;
   // revision payloads
   localparam logic [11:0] SDSC_REV_P0 = 12'h000;
   localparam logic [11:0] SDSC_REV_P1 = 12'h002;
   localparam logic [11:0] SDSC_REV_P2 = 12'h003;
   localparam logic [11:0] SDSC_REV_P3 = 12'h004;
   localparam logic [11:0] SDSC_ZERO12 = 12'h000;
   localparam logic [11:0] SDSC_ONES12 = 12'hfff;
   // diagnostic status codes
   localparam logic [11:0] SDSC_DC_OOR_HI = 12'h001;
   localparam logic [11:0] SDSC_DC_OOR_LO = 12'h002;
   localparam logic [11:0] SDSC_DC_UNDER = 12'h020;
   localparam logic [11:0] SDSC_DC_OVER = 12'h021;
   localparam logic [11:0] SDSC_DC_TEMP = 12'h022;
   localparam logic [11:0] SDSC_DC_SBE = 12'h023;
   localparam logic [11:0] SDSC_DC_ASIL = 12'h800;
   // fast channel diagnostic substitutes
   localparam logic [11:0] SDSC_FC_DIAG_A = 12'hfff;
   localparam logic [11:0] SDSC_FC_DIAG_H = 12'hffa;
   // status nibble bit positions
   localparam int SDSC_ST_DIAG = 0;
   localparam int SDSC_ST_WARN = 1;
   // link config word bit positions
   localparam int SDSC_CW1_ESP = 0;
   localparam int SDSC_CW2_MASK_DIAG = 0;
   localparam int SDSC_CW2_MASK_WARN = 1;
   // curve
   localparam int SDSC_NPTS = 17;
   localparam int SDSC_NCOEF = 16;
   localparam logic [11:0] SDSC_OUT_MAX = 12'hfff;
   typedef enum logic [2:0] {SDSC_FMT_A1, SDSC_FMT_A3, SDSC_FMT_H1, SDSC_FMT_H3,
                             SDSC_FMT_H4} sdsc_fmt_t;
   typedef enum logic [1:0] {SDSC_CAL_LINEAR, SDSC_CAL_EQUI17, SDSC_CAL_FREE} sdsc_cal_t;
endpackage : sdsc_pkg

// ### common/sdsc_coef_if.sv
// coefficient lookup carrier between the curve logic and the coefficient memory
`timescale 1ns/1ns
`default_nettype none
interface sdsc_coef_if;
   logic [3:0] addr;
   logic [11:0] rdata;
   modport user (output addr, input rdata);
   modport mem (input addr, output rdata);
endinterface : sdsc_coef_if
`default_nettype wire

// ### hdl/sdsc_coef_mem.sv
// sixteen-word coefficient memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module sdsc_coef_mem
   import sdsc_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic we_i, // write strobe
   input wire logic [3:0] waddr_i, // write index
   input wire logic [11:0] wdata_i, // write data
   sdsc_coef_if.mem port_b // read port
);
   logic [11:0] mem_r [SDSC_NCOEF];
   logic [11:0] rdata_r;
   logic [11:0] rdata_nxt;

   // read data one cycle after address
   always_comb begin
      rdata_nxt = mem_r[port_b.addr];
   end

   // storage has no reset: loaded by software after start
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
      if (rst_i) begin
         rdata_r <= SDSC_ZERO12;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign port_b.rdata = rdata_r;
endmodule : sdsc_coef_mem
`default_nettype wire

// ### hdl/sdsc_curve.sv
// output transfer characteristic: linear clamp or 17-point interpolation
`timescale 1ns/1ns
`default_nettype none
module sdsc_curve
   import sdsc_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic [1:0] cal_mode_i, // calibration type
   input wire logic neg_slope_i, // invert slope in linear mode; otherwise only picks the over-range clamp
   input wire logic [11:0] angle_i, // measured angle
   input wire logic [11:0] zero_angle_i, // reference angle
   input wire logic [11:0] range_i, // angular range
   input wire logic [11:0] clamp_switch_i, // clamp switch angle
   input wire logic [11:0] clamp_lo_i, // lower clamp
   input wire logic [11:0] clamp_hi_i, // upper clamp
   sdsc_coef_if.user coef, // coefficient lookup
   output logic [11:0] out_o // shaped output
);
   logic [11:0] rel_r, rel_nxt, frac_r, frac_nxt, lo_r, lo_nxt, out_r, out_nxt;
   logic [11:0] raw, hi_r, hi_nxt;
   logic [23:0] prod, hi_w, lo_w;
   logic [3:0] seg_r, seg_nxt;
   logic over_r, over_nxt, wrap, ph_r, ph_nxt;

   // clamp helper shared by both curve kinds
   function automatic logic [11:0] sdsc_clamp(input logic [11:0] v, input logic [11:0] lo,
                                              input logic [11:0] hi);
      sdsc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : sdsc_clamp

   // stage 1: angle relative to reference, scaled to the programmed range
   always_comb begin
      rel_nxt = angle_i - zero_angle_i;
      wrap = (rel_nxt >= clamp_switch_i); // beyond switch angle clamps to clamp_hi_i, or to clamp_lo_i with neg slope
      prod = (range_i == SDSC_ZERO12) ? 24'h000000 : ({12'h000, rel_nxt} << 12) / range_i;
      over_nxt = wrap | (rel_nxt >= range_i);
      seg_nxt = prod[11:8]; // points rescale with range
      frac_nxt = {prod[7:0], 4'h0};
      if (neg_slope_i) begin
         rel_nxt = SDSC_OUT_MAX - prod[11:0];
      end else begin
         rel_nxt = prod[11:0];
      end
   end
   // one read port serves both ends of a segment: odd cycles fetch the lower point,
   // so a fast angle step takes two extra cycles to settle
   assign coef.addr = ph_r ? seg_nxt - 4'h1 : seg_nxt;

   // stage 2: pick linear or interpolated level
   always_comb begin
      ph_nxt = ~ph_r;
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      // segment 0 starts from zero, every other lower point is the previous coefficient
      if (ph_r) begin
         hi_nxt = coef.rdata;
      end else begin
         lo_nxt = (seg_r == 4'h0) ? SDSC_ZERO12 : coef.rdata;
      end
      // full-width products: a 12-bit product would lose the interpolation weight
      hi_w = 24'(hi_r) * 24'(SDSC_OUT_MAX - frac_r);
      lo_w = 24'(lo_r) * 24'(SDSC_OUT_MAX - frac_r);
      raw = rel_r; // linear mode
      if (cal_mode_i != 2'(SDSC_CAL_LINEAR)) begin
         // point level from coefficient, 16 segments across 17 points
         raw = hi_r - hi_w[23:12] + lo_w[23:12];
      end
      if (over_r) begin
         raw = neg_slope_i ? clamp_lo_i : clamp_hi_i;
      end
      out_nxt = sdsc_clamp(raw, clamp_lo_i, clamp_hi_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rel_r <= SDSC_ZERO12;
         frac_r <= SDSC_ZERO12;
         lo_r <= SDSC_ZERO12;
         seg_r <= 4'h0;
         over_r <= 1'b0;
         out_r <= SDSC_ZERO12;
         ph_r <= 1'b0;
         hi_r <= SDSC_ZERO12;
      end else begin
         rel_r <= rel_nxt;
         frac_r <= frac_nxt;
         lo_r <= lo_nxt;
         seg_r <= seg_nxt;
         over_r <= over_nxt;
         out_r <= out_nxt;
         ph_r <= ph_nxt;
         hi_r <= hi_nxt;
      end
   end
   assign out_o = out_r;
endmodule : sdsc_curve
`default_nettype wire

// ### verif/sdsc_rx_model.sv
// receiver model at the far end of the slow channel: asks for messages and captures them
`timescale 1ns/1ns
`default_nettype none
module sdsc_rx_model (
   input wire logic clk_i, // 20 mhz clock
   input wire logic rst_i, // sync reset
   input wire logic req_i, // ask for the next message
   input wire logic [7:0] msg_id_i, // identifier seen
   input wire logic [11:0] msg_data_i, // payload seen
   output logic msg_next_o, // advance pulse to the sender
   output logic [7:0] rx_id_o, // captured identifier
   output logic [11:0] rx_data_o // captured payload
);
   // one-cycle advance per request; status is taken on trust, the checksum cannot cover it
   always_ff @(posedge clk_i) begin
      msg_next_o <= req_i & ~rst_i;
      rx_id_o <= msg_id_i;
      rx_data_o <= msg_data_i;
   end
endmodule : sdsc_rx_model
`default_nettype wire

// ### verif/sdsc_top_tb.sv
// self-checking bench for the slow channel, status nibble and fast channel diagnostics
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module sdsc_top_tb
   import sdsc_pkg::*;
;
   localparam logic [11:0] MAKER = 12'h3c7; // arbitrary value
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0, diag = 1'b0, sbe = 1'b0;
   logic [7:0] addr = 8'h00, temp = 8'h40, msg_id, rx_id;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [11:0] asil = 12'h000, angle = 12'h400, msg_data, fast, rx_data;
   logic [8:0] supply = 9'h123;
   logic [3:0] status;
   logic msg_next;
   int fail_count = 0, check_count = 0;
   logic [7:0] ids [18] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23,
      8'h1c, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
   logic [11:0] revs [4] = '{12'h000, 12'h002, 12'h003, 12'h004};
   logic [11:0] fdiag [5] = '{12'hfff, 12'h000, 12'hffa, 12'hffa, 12'hffa};

   always #25 clk = ~clk;

   sdsc_top #(.MAKER_CODE(MAKER)) u_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .msg_next_i(msg_next),
      .diag_mode_i(diag), .asil_flags_i(asil), .sbe_i(sbe), .angle_i(angle),
      .supply_i(supply), .temp_i(temp), .msg_id_o(msg_id), .msg_data_o(msg_data),
      .status_o(status), .fast_o(fast));
   sdsc_rx_model u_rx (.clk_i(clk), .rst_i(rst), .req_i(req), .msg_id_i(msg_id),
      .msg_data_i(msg_data), .msg_next_o(msg_next), .rx_id_o(rx_id), .rx_data_o(rx_data));

   ////////////////////////////////////////////////////////////////////////////////////////
   // bus tasks: strobes launched just after an edge, held one cycle
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rd_chk
   // ask the receiver for one message and let its capture land
   task automatic step();
      @(posedge clk) req <= 1'b1;
      @(posedge clk) req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : step
   // settle long enough for the two-stage synchronisers and the output register
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   function automatic logic [11:0] exp_pl(input int s, input logic [1:0] r);
      case (ids[s])
         SDSC_ID_DIAG: return 12'h000;
         SDSC_ID_TEMP: return {4'h0, temp};
         SDSC_ID_SUPPLY: return {3'h0, supply};
         SDSC_ID_TYPE: return 12'h059;
         SDSC_ID_UNIT: return {12{r[0]}};
         SDSC_ID_MAKER: return MAKER;
         SDSC_ID_REV: return revs[r];
         default: return 12'hc30 + 12'(17 * (s - 10));
      endcase
   endfunction : exp_pl
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////////////
   // hang guard: the whole run is far shorter than this
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr_reg(8'h00, 16'h0001);
      wr_reg(8'h01, 16'h0000);
      wr_reg(8'h03, 16'h0fff);
      wr_reg(8'h04, 16'h0000);
      wr_reg(8'h05, 16'hff00);
      wr_reg(8'h06, 16'h00ff);
      // upper nibble written as ones must not reach the payload
      for (int i = 0; i < 8; i++) wr_reg(8'h10 + 8'(i), {4'hf, 12'hc30 + 12'(17 * i)});
      rd_chk(8'h00, 16'h0001);
      rd_chk(8'h3f, 16'h0000);
      // every revision and both identity settings over a full message cycle
      for (int r = 0; r < 4; r++) begin
         wr_reg(8'h02, 16'(r) | (16'(r & 1) << 2));
         settle();
         for (int s = 0; s < 18; s++) begin
            `CHK(rx_id, ids[s])
            `CHK(rx_data, exp_pl(s, 2'(r)))
            step();
            #1;
         end
      end
      // diagnostic mode: flag, code with safety flags, substitute per format
      asil <= 12'h005;
      diag <= 1'b1;
      settle();
      `CHK(status, 4'h1)
      `CHK(rx_data, 12'h805)
      // full range from zero with open clamps: the linear output equals the angle
      for (int f = 0; f < 5; f++) begin
         wr_reg(8'h02, 16'(f) << 4);
         settle();
         if (f == 1) `CHK(fast, angle)
         else `CHK(fast, fdiag[f])
      end
      wr_reg(8'h01, 16'h0001);
      settle();
      `CHK(status[0], 1'b0)
      wr_reg(8'h00, 16'h0000);
      settle();
      `CHK(rx_data, 12'h000)
      diag <= 1'b0;
      wr_reg(8'h00, 16'h0001);
      wr_reg(8'h01, 16'h0000);
      // warnings in normal mode: single-bit error, out of range, undervoltage
      sbe <= 1'b1;
      settle();
      `CHK(status, 4'h2)
      `CHK(rx_data, SDSC_DC_SBE)
      `CHK(fast, angle)
      sbe <= 1'b0;
      wr_reg(8'h03, 16'h0100);
      settle();
      `CHK(rx_data, SDSC_DC_OOR_HI)
      rd_chk(8'h0c, 16'h2000);
      wr_reg(8'h03, 16'h0fff);
      wr_reg(8'h05, 16'hff20);
      supply <= 9'h010;
      settle();
      `CHK(rx_data, SDSC_DC_UNDER)
      wr_reg(8'h01, 16'h0002);
      settle();
      `CHK(status, 4'h0)
      // flat 17-point curve: all 16 coefficients at one level give that level beyond segment 0, which starts from zero
      for (int i = 0; i < 16; i++) wr_reg(8'h20 + 8'(i), 16'h00a5);
      wr_reg(8'h02, 16'h0100);
      settle();
      `CHK(fast, 12'h0a5)
      complete_run();
   end
endmodule : sdsc_top_tb
`default_nettype wire
